//--- verilog/pfd_regs.sv
// PLL status and fine-delay register bank behind an AHB-Lite slave
`timescale 1ns/1ps
module pfd_regs (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Monitor inputs from the analog side
  input  wire logic        osc_above_threshold,
  input  wire logic        second_reference_input_above,
  input  wire logic        first_reference_input_above,
  input  wire logic        pll_locked,
  // Controls toward the analog side
  output logic             ref_threshold_select,
  output logic             status_readback_disable,
  output logic             first_delay_capable_output_bypass,
  output logic      [2:0]  ramp_cap_count,
  output logic      [10:0] ramp_current_ua,
  output logic      [11:0] delay_fullscale_rel,
  // Interrupt
  output logic             irq
);

  // Address phase capture
  logic        wr_pend;
  logic [9:0]  wr_idx;
  logic        rd_take;
  logic [9:0]  rd_idx;

  // Control registers and the event flags
  logic        thresh_sel;
  logic        rdbk_dis;
  logic        bypass;
  logic [5:0]  ramp_cfg;
  logic [4:0]  irq_mask;
  logic [4:0]  irq_status;

  // Monitor history
  logic [3:0]  mon_now;
  logic [3:0]  mon_prev;
  logic [4:0]  ev;
  logic [3:0]  status_word;

  // Decoded transfers
  logic        accept;
  logic        wr_access;
  logic        status_clear;
  logic [4:0]  next_irq_status;
  logic [31:0] next_hrdata;
  logic [4:0]  irq_pending;

  // Write strobes, one per writable register, valid in the data phase
  logic        wr_ref_ctrl;
  logic        wr_pll_ctrl;
  logic        wr_bypass;
  logic        wr_ramp;
  logic        wr_mask;

  // Read words, each with its fields at their own bit positions
  logic [31:0] rd_ref_ctrl;
  logic [31:0] rd_pll_ctrl;
  logic [31:0] rd_status;
  logic [31:0] rd_bypass;
  logic [31:0] rd_ramp;
  logic [31:0] rd_irq_status;
  logic [31:0] rd_irq_mask;

  // Ramp decode ahead of the output flops
  logic [2:0]  dec_cap_count;
  logic [10:0] dec_current_ua;
  logic [11:0] dec_fullscale;

  // Slave is zero-wait and always answers OKAY
  assign hreadyout = 1'b1;
  assign hresp     = pfd_pkg::PFD_HRESP_OKAY;

  // A valid transfer is one selected, active and seen with the bus ready
  assign accept = hsel & hready
                & (htrans == pfd_pkg::PFD_HTRANS_NONSEQ
                   | htrans == pfd_pkg::PFD_HTRANS_SEQ);

  assign wr_access = accept & hwrite;

  // Word map, index then byte address:
  //   0x01A / 0x068  reference control, threshold select in bit 6
  //   0x01D / 0x074  loop control, readback disable in bit 4
  //   0x01F / 0x07C  loop status, monitors in bits 3 to 0, read only
  //   0x0A0 / 0x280  delay bypass in bit 0
  //   0x0A1 / 0x284  ramp capacitors in bits 5:3, current in bits 2:0
  //   0x0F0 / 0x3C0  event flags, cleared by a read
  //   0x0F1 / 0x3C4  event mask, same layout as the flags

  // Word index from the byte address; low two bits are ignored
  function automatic logic [9:0] pfd_index(input logic [31:0] addr);
    return addr[11:2];
  endfunction

  // True when the upper address bits are zero, inside the decoded window
  function automatic logic pfd_in_range(input logic [31:0] addr);
    return addr[31:12] == 20'h00000;
  endfunction

  // Write address phase is held for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 10'h000;
    end else begin
      wr_pend <= wr_access & pfd_in_range(haddr);
      wr_idx  <= pfd_index(haddr);
    end
  end

  // Read decode happens in the address phase so data is registered
  assign rd_take = accept & ~hwrite & pfd_in_range(haddr);
  assign rd_idx  = pfd_index(haddr);

  // Data-phase write hit on one register index
  function automatic logic pfd_wr_hit(input logic       pend,
                                      input logic [9:0] idx,
                                      input logic [9:0] reg_idx);
    return pend && idx == reg_idx;
  endfunction

  // Strobes decoded once so each register block is a plain enable
  assign wr_ref_ctrl = pfd_wr_hit(wr_pend, wr_idx,
                                  pfd_pkg::PFD_IDX_REF_CTRL);
  assign wr_pll_ctrl = pfd_wr_hit(wr_pend, wr_idx,
                                  pfd_pkg::PFD_IDX_PLL_CTRL);
  assign wr_bypass   = pfd_wr_hit(wr_pend, wr_idx,
                                  pfd_pkg::PFD_IDX_BYPASS_CTRL);
  assign wr_ramp     = pfd_wr_hit(wr_pend, wr_idx,
                                  pfd_pkg::PFD_IDX_RAMP_CONFIG);
  assign wr_mask     = pfd_wr_hit(wr_pend, wr_idx,
                                  pfd_pkg::PFD_IDX_IRQ_MASK);

  // Monitor levels are synchronous inputs; one stage keeps edges clean
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mon_now <= 4'h0;
    end else begin
      mon_now[pfd_pkg::PFD_BIT_OSC_ABOVE]  <= osc_above_threshold;
      mon_now[pfd_pkg::PFD_BIT_SECOND_REFERENCE_INPUT_ABOVE] <= second_reference_input_above;
      mon_now[pfd_pkg::PFD_BIT_FIRST_REFERENCE_INPUT_ABOVE] <= first_reference_input_above;
      mon_now[pfd_pkg::PFD_BIT_LOCKED]     <= pll_locked;
    end
  end

  // Previous sample for edge detection; its reset matches the idle
  // low level of the monitors so no false event follows reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mon_prev <= 4'h0;
    end else begin
      mon_prev <= mon_now;
    end
  end

  // Live status word, one bit per monitor
  always_comb begin
    status_word = 4'h0;
    status_word[pfd_pkg::PFD_BIT_OSC_ABOVE] =
      mon_now[pfd_pkg::PFD_BIT_OSC_ABOVE];
    status_word[pfd_pkg::PFD_BIT_SECOND_REFERENCE_INPUT_ABOVE] =
      mon_now[pfd_pkg::PFD_BIT_SECOND_REFERENCE_INPUT_ABOVE];
    status_word[pfd_pkg::PFD_BIT_FIRST_REFERENCE_INPUT_ABOVE] =
      mon_now[pfd_pkg::PFD_BIT_FIRST_REFERENCE_INPUT_ABOVE];
    status_word[pfd_pkg::PFD_BIT_LOCKED] =
      mon_now[pfd_pkg::PFD_BIT_LOCKED];
  end

  // Any change of one monitor bit between two samples
  function automatic logic pfd_toggled(input logic [3:0] cur,
                                       input logic [3:0] prv,
                                       input int         pos);
    return cur[pos] ^ prv[pos];
  endfunction

  // Events: lock edges and any crossing of a frequency threshold
  always_comb begin
    ev = 5'h00;
    ev[pfd_pkg::PFD_EV_LOCK_GAINED] =
      mon_now[pfd_pkg::PFD_BIT_LOCKED] & ~mon_prev[pfd_pkg::PFD_BIT_LOCKED];
    ev[pfd_pkg::PFD_EV_LOCK_LOST] =
      ~mon_now[pfd_pkg::PFD_BIT_LOCKED] & mon_prev[pfd_pkg::PFD_BIT_LOCKED];
    ev[pfd_pkg::PFD_EV_FIRST_REFERENCE_INPUT_CHANGE] =
      pfd_toggled(mon_now, mon_prev, pfd_pkg::PFD_BIT_FIRST_REFERENCE_INPUT_ABOVE);
    ev[pfd_pkg::PFD_EV_SECOND_REFERENCE_INPUT_CHANGE] =
      pfd_toggled(mon_now, mon_prev, pfd_pkg::PFD_BIT_SECOND_REFERENCE_INPUT_ABOVE);
    ev[pfd_pkg::PFD_EV_OSC_CHANGE] =
      pfd_toggled(mon_now, mon_prev, pfd_pkg::PFD_BIT_OSC_ABOVE);
  end

  // Threshold select for the reference monitors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thresh_sel <= pfd_pkg::PFD_RST_THRESH_SEL;
    end else if (wr_ref_ctrl) begin
      thresh_sel <= hwdata[pfd_pkg::PFD_BIT_THRESH_SEL];
    end
  end

  // Status readback disable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdbk_dis <= pfd_pkg::PFD_RST_RDBK_DIS;
    end else if (wr_pll_ctrl) begin
      rdbk_dis <= hwdata[pfd_pkg::PFD_BIT_RDBK_DIS];
    end
  end

  // Delay bypass for the first delay-capable output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bypass <= pfd_pkg::PFD_RST_BYPASS;
    end else if (wr_bypass) begin
      bypass <= hwdata[pfd_pkg::PFD_BIT_BYPASS];
    end
  end

  // Ramp capacitor and current fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_cfg <= pfd_pkg::PFD_RST_RAMP;
    end else if (wr_ramp) begin
      ramp_cfg <= hwdata[5:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= pfd_pkg::PFD_RST_IRQ_MASK;
    end else if (wr_mask) begin
      irq_mask <= hwdata[4:0];
    end
  end

  // Reading the event register clears it; a new event in that cycle stays
  assign status_clear = rd_take && rd_idx == pfd_pkg::PFD_IDX_IRQ_STATUS;

  always_comb begin
    next_irq_status = status_clear ? 5'h00 : irq_status;
    next_irq_status = next_irq_status | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 5'h00;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Level interrupt while any unmasked event is pending
  assign irq_pending = irq_status & irq_mask;
  assign irq         = |irq_pending;

  // Read words; status reads as zero while readback is disabled
  always_comb begin
    rd_ref_ctrl   = 32'h00000000;
    rd_pll_ctrl   = 32'h00000000;
    rd_status     = 32'h00000000;
    rd_bypass     = 32'h00000000;
    rd_ramp       = 32'h00000000;
    rd_irq_status = 32'h00000000;
    rd_irq_mask   = 32'h00000000;
    rd_ref_ctrl[pfd_pkg::PFD_BIT_THRESH_SEL] = thresh_sel;
    rd_pll_ctrl[pfd_pkg::PFD_BIT_RDBK_DIS]   = rdbk_dis;
    rd_status[3:0]     = rdbk_dis ? 4'h0 : status_word;
    rd_bypass[pfd_pkg::PFD_BIT_BYPASS] = bypass;
    rd_ramp[5:0]       = ramp_cfg;
    rd_irq_status[4:0] = irq_status;
    rd_irq_mask[4:0]   = irq_mask;
  end

  // Read mux over the word index; unmapped indices read zero
  always_comb begin
    unique case (rd_idx)
      pfd_pkg::PFD_IDX_REF_CTRL:    next_hrdata = rd_ref_ctrl;
      pfd_pkg::PFD_IDX_PLL_CTRL:    next_hrdata = rd_pll_ctrl;
      pfd_pkg::PFD_IDX_PLL_STATUS:  next_hrdata = rd_status;
      pfd_pkg::PFD_IDX_BYPASS_CTRL: next_hrdata = rd_bypass;
      pfd_pkg::PFD_IDX_RAMP_CONFIG: next_hrdata = rd_ramp;
      pfd_pkg::PFD_IDX_IRQ_STATUS:  next_hrdata = rd_irq_status;
      pfd_pkg::PFD_IDX_IRQ_MASK:    next_hrdata = rd_irq_mask;
      default:                      next_hrdata = 32'h00000000;
    endcase
  end

  // Read data registered at the address phase, held until the next read
  // so a master that samples late in the data phase still sees it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_take) begin
      hrdata <= next_hrdata;
    end else if (accept && !hwrite) begin
      hrdata <= 32'h00000000;
    end
  end

  // Analog-side controls come straight from their registers
  assign ref_threshold_select              = thresh_sel;
  assign status_readback_disable           = rdbk_dis;
  assign first_delay_capable_output_bypass = bypass;

  // Decode of the ramp settings into count, current and full scale
  pfd_ramp_decode i_pfd_ramp_decode (
    .ramp_cfg        (ramp_cfg),
    .cap_count       (dec_cap_count),
    .ramp_current_ua (dec_current_ua),
    .fullscale_rel   (dec_fullscale)
  );

  // Decoded settings leave through flops so the analog side sees no
  // decode glitches; the price is one clock behind the register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_cap_count      <= pfd_pkg::PFD_CAP_MAX;
      ramp_current_ua     <= pfd_pkg::PFD_CUR_STEP_UA;
      delay_fullscale_rel <= {2'h0, pfd_pkg::PFD_FS_NUMERATOR}
                             * {9'h000, pfd_pkg::PFD_CAP_MAX};
    end else begin
      ramp_cap_count      <= dec_cap_count;
      ramp_current_ua     <= dec_current_ua;
      delay_fullscale_rel <= dec_fullscale;
    end
  end

endmodule

//--- verilog/pfd_pkg.sv
// Package: register map, field layout and reset values of the delay bank
// Operation
// - Status bit 3 reads 1 while oscillator frequency is above threshold.
// - Status bit 2 reads 1 while second reference exceeds threshold.
// - Status bit 1 for first reference; threshold chosen by bit 6 of 0x01A.
// - Status bit 0 reads 1 while the loop is digitally locked.
// - Ramp capacitor field [5:3]: 000 gives 4, one bit 3, two 2, 111 one.
// - Ramp current field [2:0] gives 200 uA plus 200 uA per step.
// - Full-scale delay follows jointly from capacitor count and current.
// - Bit 4 of control register 0x01D set suppresses status readback.
package pfd_pkg;

  // Register indices as printed; the byte address is four times the index
  localparam logic [9:0] PFD_IDX_REF_CTRL     = 10'h01A;
  localparam logic [9:0] PFD_IDX_PLL_CTRL     = 10'h01D;
  localparam logic [9:0] PFD_IDX_PLL_STATUS   = 10'h01F;
  localparam logic [9:0] PFD_IDX_BYPASS_CTRL  = 10'h0A0;
  localparam logic [9:0] PFD_IDX_RAMP_CONFIG  = 10'h0A1;
  localparam logic [9:0] PFD_IDX_IRQ_STATUS   = 10'h0F0;
  localparam logic [9:0] PFD_IDX_IRQ_MASK     = 10'h0F1;

  // Field positions
  localparam int PFD_BIT_THRESH_SEL  = 6;
  localparam int PFD_BIT_RDBK_DIS    = 4;
  localparam int PFD_BIT_OSC_ABOVE   = 3;
  localparam int PFD_BIT_SECOND_REFERENCE_INPUT_ABOVE  = 2;
  localparam int PFD_BIT_FIRST_REFERENCE_INPUT_ABOVE  = 1;
  localparam int PFD_BIT_LOCKED      = 0;
  localparam int PFD_BIT_BYPASS      = 0;
  localparam int PFD_CAP_MSB         = 5;
  localparam int PFD_CAP_LSB         = 3;
  localparam int PFD_CUR_MSB         = 2;
  localparam int PFD_CUR_LSB         = 0;

  // Interrupt event bits
  localparam int PFD_EV_LOCK_GAINED  = 0;
  localparam int PFD_EV_LOCK_LOST    = 1;
  localparam int PFD_EV_FIRST_REFERENCE_INPUT_CHANGE  = 2;
  localparam int PFD_EV_SECOND_REFERENCE_INPUT_CHANGE  = 3;
  localparam int PFD_EV_OSC_CHANGE   = 4;
  localparam int PFD_EV_WIDTH        = 5;

  // Reset values
  localparam logic       PFD_RST_THRESH_SEL = 1'b0;
  localparam logic       PFD_RST_RDBK_DIS   = 1'b0;
  localparam logic       PFD_RST_BYPASS     = 1'b0;
  localparam logic [5:0] PFD_RST_RAMP       = 6'h00;
  localparam logic [4:0] PFD_RST_IRQ_MASK   = 5'h00;

  // Ramp decode constants
  localparam logic [10:0] PFD_CUR_STEP_UA   = 11'h0C8;
  localparam logic [2:0]  PFD_CAP_MAX       = 3'h4;
  localparam logic [9:0]  PFD_FS_NUMERATOR  = 10'h348;

  // AHB transfer types and response
  localparam logic [1:0] PFD_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PFD_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] PFD_HSIZE_WORD    = 3'h2;
  localparam logic       PFD_HRESP_OKAY    = 1'b0;

endpackage

//--- verilog/pfd_ramp_decode.sv
// Ramp decoder: capacitor count, ramp current and relative full scale
`timescale 1ns/1ps
module pfd_ramp_decode (
  // Ramp configuration field
  input  wire logic [5:0]  ramp_cfg,
  // Decoded analog settings
  output logic      [2:0]  cap_count,
  output logic      [10:0] ramp_current_ua,
  output logic      [11:0] fullscale_rel
);

  // Ones count of the capacitor code
  function automatic logic [1:0] pfd_ones(input logic [2:0] code);
    logic [1:0] n;
    n = 2'h0;
    for (int i = 0; i < 3; i++) begin
      n = n + {1'b0, code[i]};
    end
    return n;
  endfunction

  // 840 over the step count; 840 divides evenly by steps 1 to 8
  function automatic logic [9:0] pfd_inv_steps(input logic [2:0] code);
    logic [9:0] v;
    unique case (code)
      3'h0: v = pfd_pkg::PFD_FS_NUMERATOR;
      3'h1: v = 10'h1A4;
      3'h2: v = 10'h118;
      3'h3: v = 10'h0D2;
      3'h4: v = 10'h0A8;
      3'h5: v = 10'h08C;
      3'h6: v = 10'h078;
      3'h7: v = 10'h069;
    endcase
    return v;
  endfunction

  logic [2:0] cap_code;
  logic [2:0] cur_code;
  logic [3:0] cur_steps;

  assign cap_code  = ramp_cfg[pfd_pkg::PFD_CAP_MSB:pfd_pkg::PFD_CAP_LSB];
  assign cur_code  = ramp_cfg[pfd_pkg::PFD_CUR_MSB:pfd_pkg::PFD_CUR_LSB];
  assign cur_steps = {1'b0, cur_code} + 4'h1;

  // Each set bit removes one capacitor from the ramp
  always_comb begin
    cap_count = pfd_pkg::PFD_CAP_MAX - {1'b0, pfd_ones(cap_code)};
  end

  // Current grows by one fixed step per code
  always_comb begin
    ramp_current_ua = 11'(cur_steps * pfd_pkg::PFD_CUR_STEP_UA);
  end

  // Full scale is proportional to capacitance over current
  always_comb begin
    fullscale_rel = {9'h000, cap_count}
                  * {2'h0, pfd_inv_steps(cur_code)};
  end

endmodule

//--- testbench/pfd_regs_chk.sv
// Checker for the PLL status and fine-delay register bank
`timescale 1ns/1ps
module pfd_regs_chk (
  // Clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic        hwrite,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // Monitors, controls and interrupt
  input wire logic        osc_above_threshold,
  input wire logic        second_reference_input_above,
  input wire logic        first_reference_input_above,
  input wire logic        pll_locked,
  input wire logic        ref_threshold_select,
  input wire logic        status_readback_disable,
  input wire logic        first_delay_capable_output_bypass,
  input wire logic [2:0]  ramp_cap_count,
  input wire logic [10:0] ramp_current_ua,
  input wire logic [11:0] delay_fullscale_rel,
  input wire logic        irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [3:0]  mon;
  logic [3:0]  mon_q;
  logic [2:0]  stab;
  logic [31:0] wd_q;
  logic [31:0] wd_qq;
  assign mon = {osc_above_threshold, second_reference_input_above,
                first_reference_input_above, pll_locked};
  // History; stab saturates so a status read is judged only on settled input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mon_q <= 4'h0;
      stab  <= 3'h0;
      wd_q  <= 32'h0;
      wd_qq <= 32'h0;
    end else begin
      mon_q <= mon;
      wd_q  <= hwdata;
      wd_qq <= wd_q;
      stab  <= (mon != mon_q) ? 3'h0 : (stab == 3'h7) ? stab : stab + 3'h1;
    end
  end
  // Address phase taken for a given direction and byte address
  sequence acc(logic w, logic [11:0] a);
    hsel && hready && htrans[1] && hwrite == w && haddr == {20'h0, a};
  endsequence
  // Writes land at the end of the data phase, seen one edge later
  wr_byp_a: assert property (acc(1'b1, 12'h280) |=> ##1
    first_delay_capable_output_bypass == wd_q[0]) else $error("bypass bad");
  wr_thr_a: assert property (acc(1'b1, 12'h068) |=> ##1
    ref_threshold_select == wd_q[6]) else $error("threshold select bad");
  wr_dis_a: assert property (acc(1'b1, 12'h074) |=> ##1
    status_readback_disable == wd_q[4]) else $error("readback disable bad");
  // Decoded ramp outputs are flopped, so they trail the register by one
  wr_cap_a: assert property (acc(1'b1, 12'h284) |=> ##2
    ramp_cap_count == 3'h4 - 3'($countones(wd_qq[5:3])))
    else $error("capacitor count bad");
  wr_cur_a: assert property (acc(1'b1, 12'h284) |=> ##2
    ramp_current_ua == 11'h0C8 * ({8'h0, wd_qq[2:0]} + 11'h1))
    else $error("ramp current bad");
  full_scale_a: assert property (32'(delay_fullscale_rel) *
    32'(ramp_current_ua) == 32'(ramp_cap_count) * 32'h00029040)
    else $error("full scale bad");
  rd_stat_a: assert property (acc(1'b0, 12'h07C) &&
    !status_readback_disable && stab >= 3'h5 |=> hrdata == {28'h0, mon_q})
    else $error("status readback bad");
  rd_dis_a: assert property (acc(1'b0, 12'h07C) &&
    status_readback_disable |=> hrdata == 32'h0) else $error("status shown");
  irq_clr_a: assert property (acc(1'b0, 12'h3C0) && stab >= 3'h5 |=>
    !irq) else $error("irq not cleared by read");
endmodule
bind pfd_regs pfd_regs_chk i_pfd_regs_chk (.*);

//--- testbench/test_pfd_regs.sv
// Self-checking bench for the PLL status and fine-delay register bank
`timescale 1ns/1ps
module test_pfd_regs;
  // Nets of the bank, named as its ports
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic        osc_above_threshold, second_reference_input_above;
  logic        first_reference_input_above, pll_locked;
  logic        ref_threshold_select, status_readback_disable;
  logic        first_delay_capable_output_bypass;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ramp_cap_count;
  logic [10:0] ramp_current_ua;
  logic [11:0] delay_fullscale_rel;
  wire         hready = hreadyout;
  int          failures = 0;
  int          n_checks = 0;
  int          cyc = 0;

  pfd_regs i_pfd_regs (.*);

  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      final_report;
    end
  end

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Single word transfer; waits on hready rather than assuming zero wait
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= pfd_pkg::PFD_HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(e, q);
  endtask
  task automatic mon(input logic [3:0] v);
    {osc_above_threshold, second_reference_input_above,
     first_reference_input_above, pll_locked} <= v;
    repeat (6) @(posedge hclk);
  endtask

  task automatic t_reset;
    chk(32'h4, 32'(ramp_cap_count));
    chk(32'hC8, 32'(ramp_current_ua));
    chk(32'hD20, 32'(delay_fullscale_rel));
    chk(32'h0, 32'(hresp));
    chk(32'h1, 32'(hreadyout));
    rd(32'h68, 32'h0);
    rd(32'h74, 32'h0);
    rd(32'h284, 32'h0);
    bus(1'b1, 32'h1280, 32'h1);
    bus(1'b1, 32'h300, 32'hFFFFFFFF);
    rd(32'h300, 32'h0);
    rd(32'h280, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_status;
    for (int v = 0; v < 16; v++) begin
      mon(4'(v));
      rd(32'h7C, 32'(v));
    end
    bus(1'b1, 32'h74, 32'hFF);
    rd(32'h74, 32'h10);
    chk(32'h1, 32'(status_readback_disable));
    rd(32'h7C, 32'h0);
    bus(1'b1, 32'h74, 32'h0);
    rd(32'h7C, 32'hF);
    $display("test status done");
  endtask
  task automatic t_ctrl;
    bus(1'b1, 32'h280, 32'hFFFFFFFF);
    bus(1'b1, 32'h68, 32'hFFFFFFFF);
    rd(32'h280, 32'h1);
    rd(32'h68, 32'h40);
    chk(32'h1, 32'(first_delay_capable_output_bypass));
    chk(32'h1, 32'(ref_threshold_select));
    bus(1'b1, 32'h280, 32'h0);
    bus(1'b1, 32'h68, 32'h0);
    rd(32'h280, 32'h0);
    chk(32'h0, 32'(first_delay_capable_output_bypass));
    chk(32'h0, 32'(ref_threshold_select));
    $display("test control done");
  endtask
  task automatic t_ramp;
    int k;
    for (int c = 0; c < 64; c++) begin
      bus(1'b1, 32'h284, 32'hFFFFFFC0 | c);
      rd(32'h284, 32'(c));
      k = 4 - $countones(c[5:3]);
      chk(32'(k), 32'(ramp_cap_count));
      chk((c % 8 + 1) * 32'hC8, 32'(ramp_current_ua));
      chk(k * 32'h348 / (c % 8 + 1), 32'(delay_fullscale_rel));
    end
    $display("test ramp done");
  endtask
  // Sticky events, masking and clear on read
  task automatic t_irq;
    bus(1'b0, 32'h3C0, 32'h0);
    mon(4'h0);
    rd(32'h3C0, 32'h1E);
    chk(32'h0, 32'(irq));
    bus(1'b1, 32'h3C4, 32'h1);
    rd(32'h3C4, 32'h1);
    mon(4'h8);
    chk(32'h0, 32'(irq));
    mon(4'h9);
    chk(32'h1, 32'(irq));
    rd(32'h3C0, 32'h11);
    chk(32'h0, 32'(irq));
    $display("test interrupt done");
  endtask

  task final_report;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = pfd_pkg::PFD_HSIZE_WORD;
    hwdata = 32'h0;
    {osc_above_threshold, second_reference_input_above,
     first_reference_input_above, pll_locked} = 4'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_status;
    t_ctrl;
    t_ramp;
    t_irq;
    final_report;
  end
endmodule
